// ==== rtl/tpif_core.sv ====
// tpif_core: timer interrupt flags, external pin interrupts, mcu control bits
// assumes timers, cpu sequencer and port logic run on sys_clk; pins are async
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

module tpif_core
(
   input  wire logic                     sys_clk,
   input  wire logic                     sys_rst,
   input  wire tpif_pkg::tpif_reg_req_t  reg_req,
   output logic [7:0]                    reg_rdata,
   input  wire logic                     global_irq_enable,
   input  wire logic                     vec_exec,
   input  wire logic [7:0]               vec_addr,
   input  wire tpif_pkg::tpif_tmr_evt_t  tmr_evt,
   input  wire logic                     cnt1_pwm_mode,
   input  wire logic [15:0]              cnt1_value,
   input  wire logic [15:0]              cnt1_compare_a_value,
   input  wire logic [15:0]              cnt1_compare_b_value,
   input  wire logic [7:0]               cnt2_value,
   input  wire logic [7:0]               cnt2_compare_value,
   input  wire logic [7:0]               cnt0_value,
   input  wire logic [7:0]               cnt0_compare_value,
   input  wire logic                     ext_irq_pin_a,
   input  wire logic                     ext_irq_pin_b,
   input  wire logic                     ext_irq_pin_c,
   input  wire logic                     sleep_instr,
   input  wire tpif_pkg::tpif_port_dir_t port_dir,
   input  wire logic                     xmem_ad_drive,
   output logic [7:0]                    timer_irq_req,
   output logic [2:0]                    pin_irq_req,
   output logic                          sleep_enter,
   output tpif_pkg::tpif_sleep_t         sleep_kind,
   output logic                          ext_memory_enable,
   output logic [6:0]                    xmem_wait_cfg,
   output tpif_pkg::tpif_port_dir_t      port_dir_eff
);

   logic [7:0]                  mcu_general_control;
   logic [7:0]                  mcu_extended_control;
   logic [7:0]                  timer_irq_mask;
   logic [7:0]                  timer_interrupt_flags;
   logic [7:0]                  pin_irq_mask;
   logic [7:0]                  pin_irq_flags;
   logic [7:0]                  next_timer_flags;
   logic [7:0]                  next_pin_flags;
   logic [7:0]                  tmr_set;
   logic [7:0]                  tmr_vec_clr;
   logic [7:0]                  pin_set;
   logic [7:0]                  pin_vec_clr;
   logic [7:0]                  pin_level_req;
   logic [2:0]                  pin_raw;
   logic [2:0]                  pin_meta;
   logic [2:0]                  pin_sync;
   logic [2:0]                  pin_prev;
   tpif_pkg::tpif_sense_t [2:0] pin_sense;
   logic                        wr_tmr_flags;
   logic                        wr_pin_flags;

   assign pin_raw = {ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};

   // register writes
   assign wr_tmr_flags = reg_req.wr && (reg_req.addr == tpif_pkg::ADDR_TMR_FLAGS);
   assign wr_pin_flags = reg_req.wr && (reg_req.addr == tpif_pkg::ADDR_PIN_FLAGS);

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         mcu_general_control <= tpif_pkg::RST_REG;
      end
      else if (reg_req.wr && (reg_req.addr == tpif_pkg::ADDR_MCU_CTRL))
      begin
         mcu_general_control <= reg_req.wdata;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         mcu_extended_control <= tpif_pkg::RST_REG;
      end
      else if (reg_req.wr && (reg_req.addr == tpif_pkg::ADDR_MCU_EXT))
      begin
         mcu_extended_control <= reg_req.wdata;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         timer_irq_mask <= tpif_pkg::RST_REG;
      end
      else if (reg_req.wr && (reg_req.addr == tpif_pkg::ADDR_TMR_MASK))
      begin
         timer_irq_mask <= reg_req.wdata;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pin_irq_mask <= tpif_pkg::RST_REG;
      end
      else if (reg_req.wr && (reg_req.addr == tpif_pkg::ADDR_PIN_MASK))
      begin
         pin_irq_mask <= reg_req.wdata & tpif_pkg::PIN_MASK_USED;
      end
   end

   assign tmr_set[7] = cnt1_pwm_mode ? tmr_evt.cnt1_turn : tmr_evt.cnt1_wrap;
   assign tmr_set[6] = tmr_evt.cnt1_tick && (cnt1_value == cnt1_compare_a_value);
   assign tmr_set[5] = tmr_evt.cnt1_tick && (cnt1_value == cnt1_compare_b_value);
   assign tmr_set[4] = tmr_evt.cnt2_wrap;
   assign tmr_set[3] = tmr_evt.capture;
   assign tmr_set[2] = tmr_evt.cnt2_tick && (cnt2_value == cnt2_compare_value);
   assign tmr_set[1] = tmr_evt.cnt0_wrap;
   assign tmr_set[0] = tmr_evt.cnt0_tick && (cnt0_value == cnt0_compare_value);

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_tmr
         assign tmr_vec_clr[gi] = vec_exec && (vec_addr == tpif_pkg::TMR_VEC[gi]);
      end
   endgenerate

   // write one clears; set wins over clear
   always_comb
   begin
      next_timer_flags = timer_interrupt_flags;
      if (wr_tmr_flags)
      begin
         next_timer_flags = next_timer_flags & ~reg_req.wdata;
      end
      next_timer_flags = (next_timer_flags & ~tmr_vec_clr) | tmr_set;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         timer_interrupt_flags <= tpif_pkg::RST_REG;
      end
      else
      begin
         timer_interrupt_flags <= next_timer_flags;
      end
   end

   // two-stage synchroniser, then a history stage for edges
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pin_meta <= 3'h7;
         pin_sync <= 3'h7;
         pin_prev <= 3'h7;
      end
      else
      begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // pin b sense; pin a same code; pin c edge only
   assign pin_sense[0] = tpif_pkg::tpif_sense_t'(
                            mcu_general_control[tpif_pkg::MCU_SENSE_A_LSB +: 2]);
   assign pin_sense[1] = tpif_pkg::tpif_sense_t'(
                            mcu_general_control[tpif_pkg::MCU_SENSE_B_LSB +: 2]);
   assign pin_sense[2] = mcu_extended_control[tpif_pkg::EXT_PIN_C_EDGE]
                         ? tpif_pkg::SENSE_RISING : tpif_pkg::SENSE_FALLING;

   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_pin
         logic rise;
         logic fall;
         logic hit;
         assign rise = pin_sync[gi] && !pin_prev[gi];
         assign fall = !pin_sync[gi] && pin_prev[gi];
         always_comb
         begin
            unique case (pin_sense[gi])
               tpif_pkg::SENSE_LOW_LEVEL: hit = 1'b0;
               tpif_pkg::SENSE_ANY_EDGE:  hit = rise || fall;
               tpif_pkg::SENSE_FALLING:   hit = fall;
               tpif_pkg::SENSE_RISING:    hit = rise;
            endcase
         end
         // pin level read regardless of its direction
         assign pin_set[tpif_pkg::PIN_BIT[gi]] = hit;
         // low level requests while held low
         assign pin_level_req[tpif_pkg::PIN_BIT[gi]] =
            (pin_sense[gi] == tpif_pkg::SENSE_LOW_LEVEL) && !pin_sync[gi];
         // vector execution clears the pin flag
         assign pin_vec_clr[tpif_pkg::PIN_BIT[gi]] =
            vec_exec && (vec_addr == tpif_pkg::PIN_VEC[gi]);
         // request gated by mask and global bit
         assign pin_irq_req[gi] = global_irq_enable
            && pin_irq_mask[tpif_pkg::PIN_BIT[gi]]
            && (pin_irq_flags[tpif_pkg::PIN_BIT[gi]]
                || pin_level_req[tpif_pkg::PIN_BIT[gi]]);
      end
   endgenerate

   assign pin_set[4:0]       = 5'h00;
   assign pin_level_req[4:0] = 5'h00;
   assign pin_vec_clr[4:0]   = 5'h00;

   // write one clears; set wins over clear
   always_comb
   begin
      next_pin_flags = pin_irq_flags;
      if (wr_pin_flags)
      begin
         next_pin_flags = next_pin_flags & ~reg_req.wdata;
      end
      next_pin_flags = ((next_pin_flags & ~pin_vec_clr) | pin_set)
                       & tpif_pkg::PIN_MASK_USED;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pin_irq_flags <= tpif_pkg::RST_REG;
      end
      else
      begin
         pin_irq_flags <= next_pin_flags;
      end
   end

   // timer request needs global, enable and flag
   // counter-0 compare at bit 0 follows the same gate
   assign timer_irq_req = timer_interrupt_flags & timer_irq_mask
                          & {8{global_irq_enable}};

   // register read, data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_req.rd)
      begin
         unique case (reg_req.addr)
            tpif_pkg::ADDR_MCU_CTRL:  reg_rdata <= mcu_general_control;
            tpif_pkg::ADDR_MCU_EXT:   reg_rdata <= mcu_extended_control;
            tpif_pkg::ADDR_TMR_FLAGS: reg_rdata <= timer_interrupt_flags;
            tpif_pkg::ADDR_TMR_MASK:  reg_rdata <= timer_irq_mask;
            tpif_pkg::ADDR_PIN_FLAGS: reg_rdata <= pin_irq_flags;
            tpif_pkg::ADDR_PIN_MASK:  reg_rdata <= pin_irq_mask;
            default:                  reg_rdata <= 8'h00;
         endcase
      end
      else
      begin
         reg_rdata <= 8'h00;
      end
   end

   // sleep control
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sleep_enter <= 1'b0;
      end
      else
      begin
         sleep_enter <= sleep_instr && mcu_general_control[tpif_pkg::MCU_SLEEP_OK];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sleep_kind <= tpif_pkg::SLEEP_IDLE;
      end
      else
      begin
         // kind from hi and lo bits
         sleep_kind <= tpif_pkg::tpif_sleep_t'(
                          {mcu_general_control[tpif_pkg::MCU_SLEEP_HI],
                           mcu_extended_control[tpif_pkg::EXT_SLEEP_LO]});
      end
   end

   // external memory pin ownership
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ext_memory_enable <= 1'b0;
      end
      else
      begin
         ext_memory_enable <= mcu_general_control[tpif_pkg::MCU_XMEM_EN];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         xmem_wait_cfg <= 7'h00;
      end
      else
      begin
         xmem_wait_cfg <= {mcu_extended_control[tpif_pkg::EXT_WAIT_LSB +: 6],
                           mcu_general_control[tpif_pkg::MCU_XMEM_WAIT]};
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         port_dir_eff <= '0;
      end
      else
      begin
         port_dir_eff <= port_dir;
         if (mcu_general_control[tpif_pkg::MCU_XMEM_EN])
         begin
            port_dir_eff.a                          <= {8{xmem_ad_drive}};
            port_dir_eff.c                          <= 8'hff;
            port_dir_eff.d[tpif_pkg::PORTD_WR_BIT]  <= 1'b1;
            port_dir_eff.d[tpif_pkg::PORTD_RD_BIT]  <= 1'b1;
            port_dir_eff.e[tpif_pkg::PORTE_ALE_BIT] <= 1'b1;
         end
      end
   end

endmodule

// ==== rtl/tpif_pkg.sv ====
// tpif_pkg: constants and types for the timer and pin interrupt flag block
// assumes a single system clock and the plain register port of the block
package tpif_pkg;

   // register offsets on the i/o register port
   localparam logic [7:0] ADDR_MCU_CTRL   = 8'h35;
   localparam logic [7:0] ADDR_MCU_EXT    = 8'h36;
   localparam logic [7:0] ADDR_TMR_FLAGS  = 8'h38;
   localparam logic [7:0] ADDR_TMR_MASK   = 8'h39;
   localparam logic [7:0] ADDR_PIN_FLAGS  = 8'h3a;
   localparam logic [7:0] ADDR_PIN_MASK   = 8'h3b;

   // reset values
   localparam logic [7:0] RST_REG         = 8'h00;

   // mcu_general_control fields
   localparam int         MCU_XMEM_EN     = 7;
   localparam int         MCU_XMEM_WAIT   = 6;
   localparam int         MCU_SLEEP_OK    = 5;
   localparam int         MCU_SLEEP_HI    = 4;
   localparam int         MCU_SENSE_B_LSB = 2;
   localparam int         MCU_SENSE_A_LSB = 0;

   // mcu_extended_control fields
   localparam int         EXT_SLEEP_LO    = 7;
   localparam int         EXT_WAIT_LSB    = 1;
   localparam int         EXT_PIN_C_EDGE  = 0;

   // pin mask / flag positions, index 0 = pin a, 1 = pin b, 2 = pin c
   localparam logic [2:0][2:0] PIN_BIT    = {3'd5, 3'd7, 3'd6};
   localparam logic [7:0] PIN_MASK_USED   = 8'he0;

   // vector addresses, timer flags indexed by flag bit, pins by pin index
   localparam logic [7:0][7:0] TMR_VEC    = {8'h12, 8'h0e, 8'h10, 8'h0a,
                                             8'h0c, 8'h08, 8'h16, 8'h14};
   localparam logic [2:0][7:0] PIN_VEC    = {8'h06, 8'h04, 8'h02};

   // port bits taken by the external memory strobes
   localparam int         PORTD_WR_BIT    = 6;
   localparam int         PORTD_RD_BIT    = 7;
   localparam int         PORTE_ALE_BIT   = 1;

   // sense encodings shared by the pins
   typedef enum logic [1:0]
   {
      SENSE_LOW_LEVEL = 2'b00,
      SENSE_ANY_EDGE  = 2'b01,
      SENSE_FALLING   = 2'b10,
      SENSE_RISING    = 2'b11
   } tpif_sense_t;

   typedef enum logic [1:0]
   {
      SLEEP_IDLE       = 2'b00,
      SLEEP_RESERVED   = 2'b01,
      SLEEP_POWER_DOWN = 2'b10,
      SLEEP_POWER_SAVE = 2'b11
   } tpif_sleep_t;

   // register port request
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tpif_reg_req_t;

   // one-cycle event strobes from the timers
   typedef struct packed
   {
      logic cnt1_wrap;
      logic cnt1_turn;
      logic cnt1_tick;
      logic cnt2_wrap;
      logic cnt2_tick;
      logic cnt0_wrap;
      logic cnt0_tick;
      logic capture;
   } tpif_tmr_evt_t;

   // port direction set, a c d e
   typedef struct packed
   {
      logic [7:0] a;
      logic [7:0] c;
      logic [7:0] d;
      logic [7:0] e;
   } tpif_port_dir_t;

endpackage

// ==== tb/tpif_chk_assertions.sv ====
// tpif_chk: port-level assertions for tpif_core
// assumes a bind from the bench top; shadows three registers from port writes
`timescale 1ns/1ps
module tpif_chk
(
   input wire logic                    sys_clk,
   input wire logic                    sys_rst,
   input wire tpif_pkg::tpif_reg_req_t reg_req,
   input wire logic [7:0]              reg_rdata,
   input wire logic                    global_irq_enable,
   input wire logic                    vec_exec,
   input wire logic [7:0]              vec_addr,
   input wire tpif_pkg::tpif_tmr_evt_t tmr_evt,
   input wire logic                    ext_irq_pin_b,
   input wire logic                    sleep_instr,
   input wire logic [7:0]              timer_irq_req,
   input wire logic [2:0]              pin_irq_req,
   input wire logic                    sleep_enter
);
   logic [7:0] ctrl;
   logic [7:0] tmask;
   logic [7:0] pmask;
   logic       gie;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   assign gie = global_irq_enable;
   // register shadows
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         {ctrl, tmask, pmask} <= 24'h000000;
      else if (reg_req.wr)
      begin
         if (reg_req.addr == 8'h35)
            ctrl <= reg_req.wdata;
         if (reg_req.addr == 8'h39)
            tmask <= reg_req.wdata;
         if (reg_req.addr == 8'h3b)
            pmask <= reg_req.wdata;
      end
   end
   gated_req_a: assert property (timer_irq_req != 8'h00
      |-> gie && (timer_irq_req & ~tmask) == 8'h00) else $error("timer request not enabled");
   ovf0_raise_a: assert property (tmr_evt.cnt0_wrap && tmask[1] && gie
      && !(reg_req.wr && reg_req.addr == 8'h39) |=> !gie || timer_irq_req[1])
      else $error("overflow request missing");
   capture_raise_a: assert property (tmr_evt.capture && tmask[3] && gie
      && !(reg_req.wr && reg_req.addr == 8'h39) |=> !gie || timer_irq_req[3])
      else $error("capture request missing");
   vec_clear_a: assert property (vec_exec && vec_addr == 8'h16 && !tmr_evt.cnt0_wrap
      |=> !timer_irq_req[1]) else $error("vector left flag set");
   w1c_clear_a: assert property (reg_req.wr && reg_req.addr == 8'h38
      && reg_req.wdata[1] && !tmr_evt.cnt0_wrap |=> !timer_irq_req[1])
      else $error("write one left flag set");
   rdata_idle_a: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   sleep_gate_a: assert property (sleep_enter
      |-> $past(sleep_instr) && $past(ctrl[5])) else $error("sleep without permit");
   pin_gate_a: assert property (pin_irq_req[1] |-> gie && pmask[7])
      else $error("pin b request not enabled");
   level_hold_a: assert property ((gie && pmask[7] && ctrl[3:2] == 2'b00
      && !ext_irq_pin_b) [*4] |-> pin_irq_req[1]) else $error("level request missing");
endmodule

// ==== tb/tpif_core_tb_top.sv ====
// tpif_core_tb_top: directed bench for the timer and pin interrupt flags
// assumes tpif_pkg, tpif_core, tpif_cpu and tpif_chk are compiled first
`timescale 1ns/1ps
module tpif_core_tb_top;
   localparam logic [7:0] EVT [8] = '{8'h02, 8'h04, 8'h08, 8'h01, 8'h10, 8'h20, 8'h20, 8'h80};
   logic                     sys_clk = 1'b0;
   logic                     sys_rst = 1'b1;
   tpif_pkg::tpif_reg_req_t  reg_req = '0;
   logic [7:0]               reg_rdata;
   logic                     global_irq_enable = 1'b0;
   logic                     vec_exec;
   logic [7:0]               vec_addr;
   tpif_pkg::tpif_tmr_evt_t  tmr_evt = '0;
   logic                     cnt1_pwm_mode = 1'b0;
   logic [15:0]              cnt1_value = 16'h0000;
   logic [7:0]               cnt0_value = 8'ha5;
   logic [2:0]               pins = 3'b111;
   logic                     sleep_instr = 1'b0;
   tpif_pkg::tpif_port_dir_t port_dir = '0;
   logic                     xmem_ad_drive = 1'b0;
   logic                     serve = 1'b0;
   logic [7:0]               timer_irq_req;
   logic [2:0]               pin_irq_req;
   logic                     sleep_enter;
   tpif_pkg::tpif_sleep_t    sleep_kind;
   logic                     ext_memory_enable;
   logic [6:0]               xmem_wait_cfg;
   tpif_pkg::tpif_port_dir_t port_dir_eff;
   int                       n_mismatch = 0;
   int                       comparisons = 0;

   always #12.5 sys_clk = ~sys_clk;

   tpif_core u_dut
   (
      .sys_clk, .sys_rst, .reg_req, .reg_rdata, .global_irq_enable, .vec_exec, .vec_addr,
      .tmr_evt, .cnt1_pwm_mode, .cnt1_value, .cnt1_compare_a_value(16'h1234),
      .cnt1_compare_b_value(16'h4321), .cnt2_value(8'h5a), .cnt2_compare_value(8'h5a),
      .cnt0_value, .cnt0_compare_value(8'ha5), .ext_irq_pin_a(pins[0]),
      .ext_irq_pin_b(pins[1]), .ext_irq_pin_c(pins[2]), .sleep_instr, .port_dir,
      .xmem_ad_drive, .timer_irq_req, .pin_irq_req, .sleep_enter, .sleep_kind,
      .ext_memory_enable, .xmem_wait_cfg, .port_dir_eff
   );

   tpif_cpu u_cpu
   (
      .sys_clk, .sys_rst, .serve, .timer_irq_req, .pin_irq_req, .vec_exec, .vec_addr
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      reg_req.rd <= 1'b0;
      #1 chk(32'(reg_rdata), 32'(e));
   endtask

   task automatic ev(input logic [7:0] e);
      @(posedge sys_clk);
      tmr_evt <= e;
      @(posedge sys_clk);
      tmr_evt <= 8'h00;
   endtask

   task automatic slp(input logic e);
      @(posedge sys_clk);
      sleep_instr <= 1'b1;
      @(posedge sys_clk);
      sleep_instr <= 1'b0;
      #1 chk(32'(sleep_enter), 32'(e));
   endtask

   task automatic pin(input int p, input logic [1:0] s, input logic v);
      logic       hit;
      logic [7:0] fb;
      fb = 8'h01 << tpif_pkg::PIN_BIT[p];
      hit = (p == 2) ? (s[0] != v) : (s == 2'b01 || (s == 2'b10 && v) || (s == 2'b11 && !v));
      wr(8'h3b, 8'h00);
      @(posedge sys_clk);
      pins[p] <= v;
      repeat (4) @(posedge sys_clk);
      if (p == 2)
         wr(8'h36, {7'h00, s[0]});
      else
         wr(8'h35, (p == 1) ? {4'h0, s, 2'b00} : {6'h00, s});
      wr(8'h3a, 8'he0);
      wr(8'h3b, fb);
      @(posedge sys_clk);
      pins[p] <= !v;
      repeat (5) @(posedge sys_clk);
      #1 chk(32'(pin_irq_req[p]), 32'(hit || (p < 2 && s == 2'b00 && v)));
      rdc(8'h3a, hit ? fb : 8'h00);
      if (v)
      begin
         @(posedge sys_clk);
         serve <= 1'b1;
         @(posedge sys_clk);
         serve <= 1'b0;
      end
      else
         wr(8'h3a, fb);
      rdc(8'h3a, 8'h00);
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rdc(8'h35, 8'h00);
      rdc(8'h38, 8'h00);
      rdc(8'h37, 8'h00);
      wr(8'h35, 8'ha5);
      rdc(8'h35, 8'ha5);
      wr(8'h35, 8'h00);
      wr(8'h39, 8'hff);
      @(posedge sys_clk);
      global_irq_enable <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge sys_clk);
         cnt1_value <= (i == 5) ? 16'h4321 : 16'h1234;
         ev(EVT[i]);
         #1 chk(32'(timer_irq_req), 32'(8'h01 << i));
         rdc(8'h38, 8'h01 << i);
         wr(8'h38, ~(8'h01 << i));
         rdc(8'h38, 8'h01 << i);
         wr(8'h38, 8'h01 << i);
         rdc(8'h38, 8'h00);
      end
      @(posedge sys_clk);
      cnt0_value <= 8'ha4;
      ev(8'h02);
      rdc(8'h38, 8'h00);
      @(posedge sys_clk);
      cnt1_pwm_mode <= 1'b1;
      ev(8'h80);
      rdc(8'h38, 8'h00);
      ev(8'h40);
      rdc(8'h38, 8'h80);
      wr(8'h38, 8'h80);
      @(posedge sys_clk);
      global_irq_enable <= 1'b0;
      ev(8'h04);
      #1 chk(32'(timer_irq_req), 32'h0);
      @(posedge sys_clk);
      global_irq_enable <= 1'b1;
      #1 chk(32'(timer_irq_req), 32'h2);
      wr(8'h39, 8'hfd);
      #1 chk(32'(timer_irq_req), 32'h0);
      wr(8'h39, 8'hff);
      @(posedge sys_clk);
      serve <= 1'b1;
      for (int k = 0; k < 10 && timer_irq_req !== 8'h00; k++)
      begin
         @(posedge sys_clk);
         #1;
      end
      if (timer_irq_req !== 8'h00)
      begin
         $display("ERROR %0t vector service timed out", $time);
         n_mismatch++;
         complete_run;
      end
      @(posedge sys_clk);
      serve <= 1'b0;
      rdc(8'h38, 8'h00);
      @(posedge sys_clk);
      tmr_evt <= 8'h04;
      reg_req <= '{addr: 8'h38, wdata: 8'h02, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      tmr_evt <= 8'h00;
      reg_req.wr <= 1'b0;
      rdc(8'h38, 8'h02);
      wr(8'h38, 8'h02);
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h36, {k[0], 7'h00});
         wr(8'h35, {3'b000, k[1], 4'h0});
         slp(1'b0);
         wr(8'h35, {3'b001, k[1], 4'h0});
         slp(1'b1);
         chk(32'(sleep_kind), 32'(k));
      end
      @(posedge sys_clk);
      port_dir <= 32'h12345678;
      xmem_ad_drive <= 1'b1;
      wr(8'h36, 8'h54);
      wr(8'h35, 8'hc0);
      @(posedge sys_clk);
      #1 chk(port_dir_eff, 32'hffffd67a);
      chk(32'(ext_memory_enable), 32'h1);
      chk(32'(xmem_wait_cfg), 32'h55);
      wr(8'h35, 8'h00);
      @(posedge sys_clk);
      #1 chk(port_dir_eff, 32'h12345678);
      for (int p = 0; p < 3; p++)
         for (int s = 0; s < 4; s++)
            for (int v = 0; v < 2; v++)
               if (p < 2 || s < 2)
                  pin(p, s[1:0], v[0]);
      complete_run;
   end
endmodule

bind tpif_core tpif_chk u_chk
(
   .sys_clk, .sys_rst, .reg_req, .reg_rdata, .global_irq_enable, .vec_exec, .vec_addr,
   .tmr_evt, .ext_irq_pin_b, .sleep_instr, .timer_irq_req, .pin_irq_req, .sleep_enter
);

// ==== tb/tpif_cpu.sv ====
// tpif_cpu: cpu sequencer model taking the request with the lowest vector
// assumes serve is a level from the bench; one vector at a time
`timescale 1ns/1ps
module tpif_cpu
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       serve,
   input  wire logic [7:0] timer_irq_req,
   input  wire logic [2:0] pin_irq_req,
   output logic            vec_exec,
   output logic [7:0]      vec_addr
);
   logic [7:0] best;
   always_comb
   begin
      best = 8'hff;
      for (int i = 0; i < 3; i++)
         if (pin_irq_req[i] && tpif_pkg::PIN_VEC[i] < best)
            best = tpif_pkg::PIN_VEC[i];
      for (int i = 0; i < 8; i++)
         if (timer_irq_req[i] && tpif_pkg::TMR_VEC[i] < best)
            best = tpif_pkg::TMR_VEC[i];
   end
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || vec_exec || !serve || best == 8'hff)
      begin
         vec_exec <= 1'b0;
         vec_addr <= sys_rst ? 8'h00 : ~vec_addr;
      end
      else
      begin
         vec_exec <= 1'b1;
         vec_addr <= best;
      end
   end
endmodule
